// ---- verilog/rcc_run_ctrl.sv ----
`timescale 1ns/1ps
// Functional notes
// - command word is write-only; each bit a command, several per write
// - illegal combination or state: whole word rejected, sequence error flagged
// - full reset command resets run state, configuration and timeout
// - push setup copies pending configuration to hardware, no run started
// - run begin first pushes changed configuration, then starts the run
// - while running only live fields change; fixed fields frozen
// - trigger arm enables detection, with run begin or later
// - force makes a trigger without detection; with run begin acts as soft trigger
// - trigger disarm ignores pin triggers until armed again; a force is still taken
// - each run begins disarmed unless arm is in the same write
// - run end stops a run; when idle it only aborts a pending wait
// - wait ends ok on its state, timeout code on expiry, abort on stop/reset
// - acquisition: pretrigger fill first, only then triggers looked for
// - wait for trigger ends on first trigger of the run only
// - wait for done ends when run finished
// - millisecond timeout register for later waits; zero means none
// - timeout zero after reset; nonzero value kept until zero written or full reset
// - timeout expiry leaves run state untouched
// - read-only status word with independent flags
// - first trigger flag and run done flag
// - first pretrigger flag; segment pretrigger flag set per fill, cleared by trigger
// - generation: armed, trigger starts replay, end sets done and stops
module rcc_run_ctrl #(
	parameter int MS_CYCLES = rcc_pkg::MS_CYCLES
) (
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic [31:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        TRIG_PIN,
	input  wire logic        PRETRIG_FULL,
	input  wire logic        SEG_PRETRIG_FULL,
	input  wire logic        RUN_COMPLETE,
	output logic             RUN_ACTIVE,
	output logic             TRIG_ARMED,
	output logic             TRIG_ACCEPT,
	output logic             SETUP_LOAD,
	output logic             CARD_RESET,
	output logic      [15:0] FIXED_CFG,
	output logic      [15:0] LIVE_CFG
);
	rcc_pkg::rcc_state_t state;
	rcc_pkg::rcc_state_t next_state;
	rcc_pkg::rcc_wait_t  wait_kind;

	logic [29:0] idx;
	logic [31:0] wmask;
	logic [31:0] cmd;
	logic [31:0] rd_mux;
	logic [31:0] wait_tmo;
	logic [31:0] tmo_ms;
	logic [31:0] ms_count;
	logic [15:0] shadow;
	logic [2:0]  waits;
	logic [1:0]  res_code;
	logic        bus_req;
	logic        bus_do;
	logic        cmd_wr;
	logic        seq_err;
	logic        seq_err_q;
	logic        running;
	logic        mode_acq_next;
	logic        cfg_dirty;
	logic        push;
	logic        do_reset;
	logic        do_setup;
	logic        do_start;
	logic        do_arm;
	logic        do_force;
	logic        do_disarm;
	logic        do_stop;
	logic        do_wait;
	logic        abort;
	logic        force_pend;
	logic        trig_take;
	logic        seg_trig;
	logic        trig_ff1;
	logic        trig_ff2;
	logic        trig_ff3;
	logic        trig_evt;
	logic        flag_first_pretrig_full;
	logic        flag_first_trig_seen;
	logic        flag_run_done;
	logic        flag_segment_pretrig_full;
	logic        wait_hit;
	logic        timeout_hit;
	logic        ms_tick;

	// bus slave: ack one cycle after the strobe, dropped the cycle after
	assign bus_req = WB_CYC_I & WB_STB_I;
	assign bus_do  = bus_req & WB_ACK_O;
	assign idx     = WB_ADR_I[31:2];
	assign wmask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	always_ff @(posedge CLOCK) begin
		if (!NRST)
			WB_ACK_O <= 1'b0;
		else
			WB_ACK_O <= bus_req & ~WB_ACK_O;
	end

	always_comb begin
		case (idx)
			rcc_pkg::IDX_STATUS:  rd_mux = {28'h0000000, flag_segment_pretrig_full, flag_run_done,
			                               flag_first_trig_seen, flag_first_pretrig_full};
			rcc_pkg::IDX_TIMEOUT: rd_mux = tmo_ms;
			rcc_pkg::IDX_CFG:     rd_mux = {LIVE_CFG, shadow};
			rcc_pkg::IDX_RESULT:  rd_mux = {21'h000000, TRIG_ARMED, RUN_ACTIVE, seq_err_q,
			                               3'h0, (wait_kind != rcc_pkg::WK_NONE), 2'h0, res_code};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	// command word reads as zero: it is write-only
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			WB_DAT_O <= 32'h00000000;
		else if (bus_req && !WB_ACK_O && !WB_WE_I)
			WB_DAT_O <= rd_mux;
	end

	// trigger pin crosses in through two flops before the edge detector
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			trig_ff1 <= 1'b0;
			trig_ff2 <= 1'b0;
			trig_ff3 <= 1'b0;
		end else begin
			trig_ff1 <= TRIG_PIN;
			trig_ff2 <= trig_ff1;
			trig_ff3 <= trig_ff2;
		end
	end
	assign trig_evt = trig_ff2 & ~trig_ff3;

	// command decode; the write takes effect at the acked edge
	assign cmd_wr  = bus_do & WB_WE_I & (idx == rcc_pkg::IDX_CMD);
	assign cmd     = WB_DAT_I & wmask;
	assign running = (state != rcc_pkg::ST_IDLE);
	assign waits   = {cmd[rcc_pkg::CB_WAIT_DONE], cmd[rcc_pkg::CB_WAIT_TRIG],
	                  cmd[rcc_pkg::CB_WAIT_PRE]};
	assign mode_acq_next = (cmd[rcc_pkg::CB_PUSH_SETUP] || cfg_dirty) ?
	                       shadow[rcc_pkg::CF_ACQ_MODE] : FIXED_CFG[rcc_pkg::CF_ACQ_MODE];

	always_comb begin
		seq_err = 1'b0;
		if (cmd[rcc_pkg::CB_FULL_RESET] && (cmd[31:1] != 31'h00000000))
			seq_err = 1'b1;
		if (cmd[rcc_pkg::CB_RUN_BEGIN] && (running || cmd[rcc_pkg::CB_RUN_END]))
			seq_err = 1'b1;
		if (cmd[rcc_pkg::CB_PUSH_SETUP] && running)
			seq_err = 1'b1;
		if (cmd[rcc_pkg::CB_TRIG_ARM] && cmd[rcc_pkg::CB_TRIG_DISARM])
			seq_err = 1'b1;
		if ((waits & (waits - 3'h1)) != 3'h0)
			seq_err = 1'b1;
		if ((waits != 3'h0) && (wait_kind != rcc_pkg::WK_NONE))
			seq_err = 1'b1;
		if (cmd[rcc_pkg::CB_WAIT_PRE] && !mode_acq_next)
			seq_err = 1'b1;
	end

	assign do_reset  = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_FULL_RESET];
	assign do_setup  = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_PUSH_SETUP];
	assign do_start  = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_RUN_BEGIN];
	assign do_arm    = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_TRIG_ARM];
	assign do_force  = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_TRIG_FORCE];
	assign do_disarm = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_TRIG_DISARM];
	assign do_stop   = cmd_wr & ~seq_err & cmd[rcc_pkg::CB_RUN_END];
	assign do_wait   = cmd_wr & ~seq_err & (waits != 3'h0);
	assign push      = do_setup | (do_start & cfg_dirty);
	assign abort     = do_reset | do_stop;

	always_ff @(posedge CLOCK) begin
		if (!NRST)
			seq_err_q <= 1'b0;
		else if (cmd_wr)
			seq_err_q <= seq_err;
	end

	// configuration: fixed half waits for a push, live half applies at once
	always_ff @(posedge CLOCK) begin
		if (!NRST || do_reset) begin
			shadow    <= rcc_pkg::FIXED_RST;
			LIVE_CFG  <= rcc_pkg::LIVE_RST;
			FIXED_CFG <= rcc_pkg::FIXED_RST;
			cfg_dirty <= 1'b0;
		end else begin
			if (bus_do && WB_WE_I && idx == rcc_pkg::IDX_CFG) begin
				for (int i = 0; i < 2; i++) begin
					if (WB_SEL_I[i])
						shadow[8*i +: 8] <= WB_DAT_I[8*i +: 8];
					if (WB_SEL_I[i+2])
						LIVE_CFG[8*i +: 8] <= WB_DAT_I[16+8*i +: 8];
				end
			end
			if (push)
				FIXED_CFG <= shadow;
			// a write landing with a push keeps the dirty mark
			if (bus_do && WB_WE_I && idx == rcc_pkg::IDX_CFG && (WB_SEL_I[1:0] != 2'h0))
				cfg_dirty <= 1'b1;
			else if (push)
				cfg_dirty <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST || do_reset)
			tmo_ms <= rcc_pkg::TIMEOUT_RST;
		else if (bus_do && WB_WE_I && idx == rcc_pkg::IDX_TIMEOUT) begin
			for (int i = 0; i < 4; i++) begin
				if (WB_SEL_I[i])
					tmo_ms[8*i +: 8] <= WB_DAT_I[8*i +: 8];
			end
		end
	end

	// trigger engine
	assign trig_take = (state == rcc_pkg::ST_ARMED) & ((trig_evt & TRIG_ARMED) | force_pend);
	assign seg_trig  = (state == rcc_pkg::ST_RUN) & ((trig_evt & TRIG_ARMED) | force_pend);

	always_ff @(posedge CLOCK) begin
		if (!NRST || do_reset)
			TRIG_ARMED <= 1'b0;
		else if (do_start)
			TRIG_ARMED <= cmd[rcc_pkg::CB_TRIG_ARM];
		else if (do_arm)
			TRIG_ARMED <= 1'b1;
		else if (do_disarm)
			TRIG_ARMED <= 1'b0;
	end

	// a force is held until the engine is able to look for triggers
	always_ff @(posedge CLOCK) begin
		if (!NRST || abort)
			force_pend <= 1'b0;
		else if (do_force && (running || do_start))
			force_pend <= 1'b1;
		else if (trig_take || seg_trig)
			force_pend <= 1'b0;
	end

	always_comb begin
		next_state = state;
		case (state)
			rcc_pkg::ST_FILL:
				if (PRETRIG_FULL)
					next_state = rcc_pkg::ST_ARMED;
			rcc_pkg::ST_ARMED:
				if (trig_take)
					next_state = rcc_pkg::ST_RUN;
			rcc_pkg::ST_RUN:
				if (RUN_COMPLETE)
					next_state = rcc_pkg::ST_IDLE;
			default:
				next_state = rcc_pkg::ST_IDLE;
		endcase
		if (do_start)
			next_state = mode_acq_next ? rcc_pkg::ST_FILL : rcc_pkg::ST_ARMED;
		if (abort)
			next_state = rcc_pkg::ST_IDLE;
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state       <= rcc_pkg::ST_IDLE;
			RUN_ACTIVE  <= 1'b0;
			TRIG_ACCEPT <= 1'b0;
			SETUP_LOAD  <= 1'b0;
			CARD_RESET  <= 1'b0;
		end else begin
			state       <= next_state;
			RUN_ACTIVE  <= (next_state != rcc_pkg::ST_IDLE);
			TRIG_ACCEPT <= (trig_take | seg_trig) & ~abort;
			SETUP_LOAD  <= push;
			CARD_RESET  <= do_reset;
		end
	end

	// status flags: hardware set wins over a trigger clear in the same cycle; a stop or reset in that cycle blocks the set
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			flag_first_pretrig_full   <= 1'b0;
			flag_first_trig_seen      <= 1'b0;
			flag_run_done             <= 1'b0;
			flag_segment_pretrig_full <= 1'b0;
		end else begin
			if (state == rcc_pkg::ST_FILL && PRETRIG_FULL && !abort)
				flag_first_pretrig_full <= 1'b1;
			else if (do_start || do_reset)
				flag_first_pretrig_full <= 1'b0;
			if (trig_take && !abort)
				flag_first_trig_seen <= 1'b1;
			else if (do_start || do_reset)
				flag_first_trig_seen <= 1'b0;
			if (state == rcc_pkg::ST_RUN && RUN_COMPLETE && !abort)
				flag_run_done <= 1'b1;
			else if (do_start || do_reset)
				flag_run_done <= 1'b0;
			if (!abort && ((state == rcc_pkg::ST_FILL && PRETRIG_FULL) ||
			    (state == rcc_pkg::ST_RUN && SEG_PRETRIG_FULL &&
			     FIXED_CFG[rcc_pkg::CF_MULTI])))
				flag_segment_pretrig_full <= 1'b1;
			else if (trig_take || seg_trig || do_start || do_reset)
				flag_segment_pretrig_full <= 1'b0;
		end
	end

	// waits: one at a time, timeout taken at the start of the wait
	always_comb begin
		case (wait_kind)
			rcc_pkg::WK_PRE:  wait_hit = flag_first_pretrig_full;
			rcc_pkg::WK_TRIG: wait_hit = flag_first_trig_seen;
			rcc_pkg::WK_DONE: wait_hit = flag_run_done;
			default:          wait_hit = 1'b0;
		endcase
	end
	assign timeout_hit = (wait_tmo != 32'h00000000) && (ms_count == wait_tmo);

	rcc_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_ms_tick (
		.clock (CLOCK),
		.nrst  (NRST),
		.clear (wait_kind == rcc_pkg::WK_NONE),
		.tick  (ms_tick)
	);

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			wait_kind <= rcc_pkg::WK_NONE;
			res_code  <= rcc_pkg::RES_NONE;
			wait_tmo  <= 32'h00000000;
			ms_count  <= 32'h00000000;
		end else if (abort && wait_kind != rcc_pkg::WK_NONE) begin
			wait_kind <= rcc_pkg::WK_NONE;
			res_code  <= rcc_pkg::RES_ABORT;
		end else if (do_wait) begin
			wait_kind <= waits[0] ? rcc_pkg::WK_PRE :
			             waits[1] ? rcc_pkg::WK_TRIG : rcc_pkg::WK_DONE;
			res_code  <= rcc_pkg::RES_NONE;
			wait_tmo  <= tmo_ms;
			ms_count  <= 32'h00000000;
		end else if (wait_kind != rcc_pkg::WK_NONE) begin
			if (wait_hit) begin
				wait_kind <= rcc_pkg::WK_NONE;
				res_code  <= rcc_pkg::RES_OK;
			end else if (timeout_hit) begin
				wait_kind <= rcc_pkg::WK_NONE;
				res_code  <= rcc_pkg::RES_TIMEOUT;
			end else if (ms_tick)
				ms_count <= ms_count + 32'h00000001;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	sequence s_force_armed;
		do_force && state == rcc_pkg::ST_ARMED && !abort;
	endsequence
	sequence s_ignored_trig;
		state == rcc_pkg::ST_ARMED && !TRIG_ARMED && !force_pend && trig_evt && !cmd_wr;
	endsequence

	property p_reject;
		cmd_wr && seq_err && !running |=> !RUN_ACTIVE && seq_err_q && !SETUP_LOAD && !CARD_RESET;
	endproperty
	a_reject: assert property (p_reject) else $error("rejected command acted");

	property p_reset;
		do_reset |=> CARD_RESET && !RUN_ACTIVE && !TRIG_ARMED && tmo_ms == 32'h00000000;
	endproperty
	a_reset: assert property (p_reset) else $error("reset incomplete");

	property p_setup;
		do_setup && !do_start |=> SETUP_LOAD && !RUN_ACTIVE && FIXED_CFG == $past(shadow);
	endproperty
	a_setup: assert property (p_setup) else $error("setup push wrong");

	property p_start_push;
		do_start && cfg_dirty |=> SETUP_LOAD && RUN_ACTIVE && FIXED_CFG == $past(shadow);
	endproperty
	a_start_push: assert property (p_start_push) else $error("start did not push");

	property p_fixed_hold;
		RUN_ACTIVE && !do_reset |=> $stable(FIXED_CFG);
	endproperty
	a_fixed_hold: assert property (p_fixed_hold) else $error("fixed config moved in run");

	property p_start_arm;
		do_start |=> TRIG_ARMED == $past(cmd[rcc_pkg::CB_TRIG_ARM]);
	endproperty
	a_start_arm: assert property (p_start_arm) else $error("arm state after start");

	property p_force;
		s_force_armed ##1 !abort |-> ##1 TRIG_ACCEPT;
	endproperty
	a_force: assert property (p_force) else $error("force gave no trigger");

	property p_disarmed;
		s_ignored_trig |=> !TRIG_ACCEPT && state == rcc_pkg::ST_ARMED;
	endproperty
	a_disarmed: assert property (p_disarmed) else $error("trigger taken while disarmed");

	property p_stop;
		do_stop |=> !RUN_ACTIVE && !TRIG_ACCEPT;
	endproperty
	a_stop: assert property (p_stop) else $error("run end ignored");

	property p_wait_ok;
		wait_kind != rcc_pkg::WK_NONE && wait_hit && !abort |=>
			wait_kind == rcc_pkg::WK_NONE && res_code == rcc_pkg::RES_OK;
	endproperty
	a_wait_ok: assert property (p_wait_ok) else $error("wait not completed");

	property p_timeout;
		wait_kind != rcc_pkg::WK_NONE && timeout_hit && !wait_hit && !abort && !do_arm &&
			!do_disarm && !do_start |=>
			res_code == rcc_pkg::RES_TIMEOUT && $stable(TRIG_ARMED);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout result wrong");

	property p_fill_gate;
		state == rcc_pkg::ST_FILL |=> !TRIG_ACCEPT;
	endproperty
	a_fill_gate: assert property (p_fill_gate) else $error("trigger during pretrigger fill");

	property p_done;
		state == rcc_pkg::ST_RUN && RUN_COMPLETE && !cmd_wr |=> flag_run_done && !RUN_ACTIVE;
	endproperty
	a_done: assert property (p_done) else $error("run end not flagged");

	property p_first_trig;
		trig_take && !abort |=> flag_first_trig_seen && TRIG_ACCEPT;
	endproperty
	a_first_trig: assert property (p_first_trig) else $error("first trigger not flagged");

	property p_start_clear;
		do_start |=> !flag_first_trig_seen && !flag_run_done && !flag_first_pretrig_full;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("stale flags after start");

endmodule // rcc_run_ctrl

// ---- verilog/rcc_pkg.sv ----
package rcc_pkg;

	// register indices; byte address is four times the index
	localparam logic [29:0] IDX_CMD     = 30'h0000064;
	localparam logic [29:0] IDX_STATUS  = 30'h000006e;
	localparam logic [29:0] IDX_TIMEOUT = 30'h00480da;
	localparam logic [29:0] IDX_CFG     = 30'h0000200;
	localparam logic [29:0] IDX_RESULT  = 30'h0000201;

	// command word bits
	localparam int CB_FULL_RESET  = 0;
	localparam int CB_PUSH_SETUP  = 1;
	localparam int CB_RUN_BEGIN   = 2;
	localparam int CB_TRIG_ARM    = 3;
	localparam int CB_TRIG_FORCE  = 4;
	localparam int CB_TRIG_DISARM = 5;
	localparam int CB_RUN_END     = 6;
	localparam int CB_WAIT_PRE    = 12;
	localparam int CB_WAIT_TRIG   = 13;
	localparam int CB_WAIT_DONE   = 14;

	// status word bits
	localparam int SB_FIRST_PRETRIG = 0;
	localparam int SB_FIRST_TRIG    = 1;
	localparam int SB_RUN_DONE      = 2;
	localparam int SB_SEG_PRETRIG   = 3;

	// result register fields
	localparam int RF_CODE_LSB = 0;
	localparam int RF_BUSY     = 4;
	localparam int RF_SEQ_ERR  = 8;
	localparam int RF_RUNNING  = 9;
	localparam int RF_ARMED    = 10;

	// configuration register fields
	localparam int CF_ACQ_MODE  = 0;
	localparam int CF_MULTI     = 1;
	localparam int CF_FIXED_W   = 16;
	localparam int CF_LIVE_LSB  = 16;
	localparam int CF_LIVE_W    = 16;

	// values after reset
	localparam logic [31:0] TIMEOUT_RST = 32'h00000000;
	localparam logic [15:0] FIXED_RST   = 16'h0000;
	localparam logic [15:0] LIVE_RST    = 16'h0000;

	// wait result codes
	localparam logic [1:0] RES_NONE    = 2'h0;
	localparam logic [1:0] RES_OK      = 2'h1;
	localparam logic [1:0] RES_TIMEOUT = 2'h2;
	localparam logic [1:0] RES_ABORT   = 2'h3;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_ARMED, ST_RUN} rcc_state_t;
	typedef enum logic [1:0] {WK_NONE, WK_PRE, WK_TRIG, WK_DONE} rcc_wait_t;

endpackage

// ---- verilog/rcc_ms_tick.sv ----
`timescale 1ns/1ps
module rcc_ms_tick #(
	parameter int CYCLES = rcc_pkg::MS_CYCLES
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic clear,
	output logic      tick
);
	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;

	// restarts with each wait so the first millisecond is a whole one
	always_ff @(posedge clock) begin
		if (!nrst || clear) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // rcc_ms_tick

// ---- testbench/rcc_run_ctrl_bench.sv ----
`timescale 1ns/1ps
module rcc_run_ctrl_bench;
	// shortened millisecond so timeout waits stay short
	localparam int MSC = 20;
	localparam int LIMIT = 20000;

	logic        clock;
	logic        nrst;
	logic        we;
	logic        cyc;
	logic        stb;
	logic        trig;
	logic        pre;
	logic        done;
	logic        seg;
	logic [31:0] adr;
	logic [31:0] dat;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic [3:0]  sel;
	logic        ack;
	logic        run_act;
	logic        armed;
	logic        t_acc;
	logic        s_load;
	logic        c_rst;
	logic [15:0] fixed;
	logic [15:0] live;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc_n = 0;
	int          acc_n = 0;
	int          rst_n = 0;
	int          load_n = 0;

	rcc_run_ctrl #(.MS_CYCLES(MSC)) dut_u (
		.CLOCK           (clock),
		.NRST            (nrst),
		.WB_ADR_I        (adr),
		.WB_DAT_I        (dat),
		.WB_WE_I         (we),
		.WB_SEL_I        (sel),
		.WB_CYC_I        (cyc),
		.WB_STB_I        (stb),
		.WB_DAT_O        (dat_o),
		.WB_ACK_O        (ack),
		.TRIG_PIN        (trig),
		.PRETRIG_FULL    (pre),
		.SEG_PRETRIG_FULL(seg),
		.RUN_COMPLETE    (done),
		.RUN_ACTIVE      (run_act),
		.TRIG_ARMED      (armed),
		.TRIG_ACCEPT     (t_acc),
		.SETUP_LOAD      (s_load),
		.CARD_RESET      (c_rst),
		.FIXED_CFG       (fixed),
		.LIVE_CFG        (live)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// pulse outputs are counted so no single-cycle event is missed
	always @(posedge clock) begin
		cyc_n <= cyc_n + 1;
		if (t_acc === 1'b1) acc_n <= acc_n + 1;
		if (c_rst === 1'b1) rst_n <= rst_n + 1;
		if (s_load === 1'b1) load_n <= load_n + 1;
	end

	always @(posedge clock) begin
		if (cyc_n == LIMIT) begin
			error_cnt = error_cnt + 1;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one classic cycle; released only after ack is sampled
	task automatic wb(input logic w, input logic [29:0] idx, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		sel <= 4'hf;
		// no cap here: a missing ack is caught by the cycle limit
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic cmd(input logic [31:0] d);
		wb(1'b1, rcc_pkg::IDX_CMD, d);
		// one more edge so the pulse counters have seen the outputs
		@(posedge clock);
		@(negedge clock);
	endtask

	task automatic rchk(input string nm, input logic [29:0] idx, input logic [31:0] m,
			input logic [31:0] e);
		wb(1'b0, idx, 32'h00000000);
		chk(nm, e, q & m);
	endtask

	// 0 pin, 1 pretrigger full, 3 segment full, other run complete
	task automatic pul(input int k);
		@(posedge clock);
		case (k)
			0: trig <= 1'b1;
			1: pre <= 1'b1;
			3: seg <= 1'b1;
			default: done <= 1'b1;
		endcase
		@(posedge clock);
		trig <= 1'b0;
		pre <= 1'b0;
		seg <= 1'b0;
		done <= 1'b0;
		// pin passes a synchroniser before it counts
		repeat (6) @(posedge clock);
	endtask

	task automatic wfin();
		int n;
		n = 0;
		do begin
			wb(1'b0, rcc_pkg::IDX_RESULT, 32'h00000000);
			n++;
		end while (q[rcc_pkg::RF_BUSY] !== 1'b0 && n < 200);
	endtask

	initial begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 32'h00000000;
		dat = 32'h00000000;
		sel = 4'h0;
		trig = 1'b0;
		pre = 1'b0;
		done = 1'b0;
		seg = 1'b0;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		rchk("timeout", rcc_pkg::IDX_TIMEOUT, 32'hffffffff, 32'h00000000);
		rchk("status", rcc_pkg::IDX_STATUS, 32'hffffffff, 32'h00000000);
		rchk("command", rcc_pkg::IDX_CMD, 32'hffffffff, 32'h00000000);
		rchk("unmapped", 30'h00000300, 32'hffffffff, 32'h00000000);
		// acquisition run
		wb(1'b1, rcc_pkg::IDX_CFG, 32'h12340003);
		wb(1'b1, rcc_pkg::IDX_TIMEOUT, 32'h00000003);
		rchk("timeout", rcc_pkg::IDX_TIMEOUT, 32'hffffffff, 32'h00000003);
		cmd(32'h00000002);
		chk("fixed", 32'h00000003, {16'h0000, fixed});
		chk("live", 32'h00001234, {16'h0000, live});
		chk("load", 32'h00000001, load_n);
		chk("run", 32'h00000000, {31'h0, run_act});
		cmd(32'h0000000c);
		chk("run", 32'h00000001, {31'h0, run_act});
		chk("armed", 32'h00000001, {31'h0, armed});
		pul(0);
		chk("accepts", 32'h00000000, acc_n);
		cmd(32'h00001000);
		pul(1);
		wfin();
		chk("pre wait", 32'h00000001, q & 32'h00000013);
		rchk("status", rcc_pkg::IDX_STATUS, 32'h00000009, 32'h00000009);
		wb(1'b1, rcc_pkg::IDX_CFG, 32'habcd0002);
		@(negedge clock);
		chk("live", 32'h0000abcd, {16'h0000, live});
		chk("fixed", 32'h00000003, {16'h0000, fixed});
		cmd(32'h00002000);
		pul(0);
		wfin();
		chk("trig wait", 32'h00000001, q & 32'h00000013);
		chk("accepts", 32'h00000001, acc_n);
		rchk("status", rcc_pkg::IDX_STATUS, 32'h0000000b, 32'h00000003);
		// multi mode: a segment fill during the run raises the segment flag
		pul(3);
		rchk("segment", rcc_pkg::IDX_STATUS, 32'h00000008, 32'h00000008);
		cmd(32'h00004000);
		wfin();
		chk("done wait", 32'h00000002, q & 32'h00000013);
		@(negedge clock);
		chk("run", 32'h00000001, {31'h0, run_act});
		pul(2);
		rchk("status", rcc_pkg::IDX_STATUS, 32'h00000007, 32'h00000007);
		chk("run", 32'h00000000, {31'h0, run_act});
		// generation run, timeout off
		wb(1'b1, rcc_pkg::IDX_CFG, 32'h00000000);
		wb(1'b1, rcc_pkg::IDX_TIMEOUT, 32'h00000000);
		cmd(32'h00000004);
		chk("armed", 32'h00000000, {31'h0, armed});
		chk("fixed", 32'h00000000, {16'h0000, fixed});
		rchk("status", rcc_pkg::IDX_STATUS, 32'h0000000f, 32'h00000000);
		cmd(32'h00000008);
		cmd(32'h00000020);
		pul(0);
		chk("accepts", 32'h00000001, acc_n);
		chk("armed", 32'h00000000, {31'h0, armed});
		cmd(32'h00000018);
		repeat (3) @(posedge clock);
		rchk("status", rcc_pkg::IDX_STATUS, 32'h00000002, 32'h00000002);
		chk("accepts", 32'h00000002, acc_n);
		cmd(32'h00004000);
		repeat (200) @(posedge clock);
		rchk("no timeout", rcc_pkg::IDX_RESULT, 32'h00000013, 32'h00000010);
		cmd(32'h00000040);
		rchk("abort", rcc_pkg::IDX_RESULT, 32'h00000013, 32'h00000003);
		chk("run", 32'h00000000, {31'h0, run_act});
		cmd(32'h00000040);
		rchk("idle stop", rcc_pkg::IDX_RESULT, 32'h00000100, 32'h00000000);
		cmd(32'h00000005);
		rchk("seq err", rcc_pkg::IDX_RESULT, 32'h00000100, 32'h00000100);
		chk("run", 32'h00000000, {31'h0, run_act});
		wb(1'b1, rcc_pkg::IDX_TIMEOUT, 32'h00000007);
		cmd(32'h00000001);
		chk("resets", 32'h00000001, rst_n);
		rchk("timeout", rcc_pkg::IDX_TIMEOUT, 32'hffffffff, 32'h00000000);
		test_done();
	end
endmodule // rcc_run_ctrl_bench
